// ### trig_mon_cfg.svh
// constants for the trigger and analog monitor logic
`ifndef TRIG_MON_CFG_SVH
`define TRIG_MON_CFG_SVH

// geometry
`define NCH 8
`define SMP_W 12
`define NSAMP 5
`define NTH_W 8
`define COINC_W 3
`define NLVDS 16
`define SYNC_W 2

// clock and converter rates
`define CLK_HZ 200000000
`define DAC_HZ 100000000
`define DAC_DIV (`CLK_HZ / `DAC_HZ)
`define DIV_W 4
`define DAC_W 12
`define DAC_CODES 4096
`define DAC_MAX 12'hFFF
`define DAC_ZERO 12'h000

// analog monitor scaling, full scale is one volt
`define FS_UV 1000000
`define MAJ_STEP_UV 125000
`define BUF_STEP_NV 976000
`define MAJ_STEP ((`MAJ_STEP_UV * `DAC_CODES + `FS_UV / 2) / `FS_UV)
`define BUF_STEP ((`BUF_STEP_NV / 1000 * `DAC_CODES + `FS_UV / 2) / `FS_UV)
`define SAW_FREQ_MHZ 30518
`define SAW_DIV ((64'd1000 * `DAC_HZ + (64'd`SAW_FREQ_MHZ * `DAC_CODES) / 2) / (64'd`SAW_FREQ_MHZ * `DAC_CODES))
`define SAW_W 10

// monitor mode codes
`define MODE_W 3
`define MODE_MAJ 3'h0
`define MODE_TEST 3'h1
`define MODE_RSVD 3'h2
`define MODE_BUF 3'h3
`define MODE_LEVEL 3'h4

// lvds default map
`define LV_MEM_FULL 8
`define LV_EVT_RDY 9
`define LV_CH_TRIG 10
`define LV_RUN 11
`define LV_TTAG_RST 12
`define LV_MEM_CLR 13
`define LV_OUT_MASK 16'h0FFF

`endif

// ### trig_mon_pkg.sv
// types and helpers shared by the trigger and monitor modules
`default_nettype none
`include "trig_mon_cfg.svh"
package trig_mon_pkg;
  typedef logic [`NSAMP-1:0][`SMP_W-1:0] grp_t;
  typedef logic [`SMP_W-1:0] smp_t;
  typedef logic [`NCH-1:0] chmask_t;
  typedef logic [3:0] chcnt_t;

  function automatic chcnt_t popcount(input chmask_t v);
    chcnt_t n;
    n = 4'h0;
    for (int k = 0; k < `NCH; k++)
    begin
      n = n + chcnt_t'(v[k]);
    end
    return n;
  endfunction
endpackage
`default_nettype wire

// ### chan_trig_if.sv
// signals between the central trigger logic and one channel discriminator
`timescale 1ns/100ps
`default_nettype none
`include "trig_mon_cfg.svh"
interface chan_trig_if;
  trig_mon_pkg::grp_t grp;
  logic grp_valid;
  logic grp_five;
  trig_mon_pkg::smp_t thr;
  logic neg;
  logic [`NTH_W-1:0] nth;
  logic over;
  logic req;
  modport central (output grp, grp_valid, grp_five, thr, neg, nth, input over, req);
  modport chan (input grp, grp_valid, grp_five, thr, neg, nth, output over, req);
endinterface
`default_nettype wire

// ### chan_discrim.sv
// one channel threshold discriminator with consecutive group count
`timescale 1ns/100ps
`default_nettype none
`include "trig_mon_cfg.svh"
module chan_discrim
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // link to central logic
  chan_trig_if.chan ct
);
  logic [`NSAMP-1:0] smp_hi;
  logic [`NSAMP-1:0] smp_lo;
  logic [`NSAMP-1:0] smp_use;
  logic grp_hit;
  logic [`NTH_W-1:0] cnt_r;
  logic [`NTH_W-1:0] cnt_nxt;
  logic over_r;
  logic hit_r;
  logic hit_nxt;
  logic req_r;

  genvar s;
  generate
    for (s = 0; s < `NSAMP; s++)
    begin : g_smp
      assign smp_hi[s] = ct.grp[s] >= ct.thr;
      assign smp_lo[s] = ct.grp[s] < ct.thr;
      assign smp_use[s] = (s < `NSAMP - 1) || ct.grp_five;
    end
  endgenerate

  assign grp_hit = ct.neg ? |(smp_lo & smp_use) : |(smp_hi & smp_use);
  // saturate so a long pulse never wraps and re-fires
  assign cnt_nxt = !grp_hit ? '0 : ((&cnt_r) ? cnt_r : cnt_r + 1'b1);
  assign hit_nxt = grp_hit && (cnt_nxt >= ct.nth);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cnt_r <= '0;
      over_r <= 1'b0;
      hit_r <= 1'b0;
      req_r <= 1'b0;
    end
    else if (ct.grp_valid)
    begin
      cnt_r <= cnt_nxt;
      over_r <= grp_hit;
      hit_r <= hit_nxt;
      req_r <= hit_nxt && !hit_r;
    end
    else
    begin
      req_r <= 1'b0;
    end
  end

  assign ct.over = over_r;
  assign ct.req = req_r;

  a_req_needs_over: assert property (@(posedge i_clk) disable iff (!i_nrst)
    req_r |-> over_r && hit_r)
    else $error("channel request without group over threshold");
  a_neg_strict: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ct.grp_valid && ct.neg && ct.grp[0] == ct.thr && ct.grp[1] == ct.thr && ct.grp[2] == ct.thr
     && ct.grp[3] == ct.thr && (!ct.grp_five || ct.grp[4] == ct.thr)) |=> !over_r)
    else $error("sample equal to threshold counted under in negative logic");
endmodule
`default_nettype wire

// ### trig_mon_top.sv
// trigger merge, lvds front panel lines and analog monitor converter control
`timescale 1ns/100ps
`default_nettype none
`include "trig_mon_cfg.svh"
// Overview of operation
// - one global trigger pulse goes to all eight channels together
// - external trigger passes two flops; up to one clock of jitter
// - a host write to the trigger register raises a software trigger
// - channel requests after level crossed for programmed count of sample groups
// - threshold, direction and group count are per-channel settings
// - channel requests feed the central merge and default lvds lines 0-7, never start capture
// - three-bit coincidence level and eight-bit channel enable mask
// - a request counts only with enough other channels over in that cycle
// - global trigger is a one-clock pulse on the rise of the OR of enabled sources, clocked internally
// - trigger output is driven from its own selected sources
// - sixteen lvds lines with host-programmed function and direction
// - default lines 0-7 channel requests, 8-11 status outputs
// - default line 12 time-tag reset, 13 memory clear, both active low
// - twelve-bit monitor code updated at one hundred megahertz
// - monitor mode 0,1,3,4 select source; 2 reserved
// - majority mode gives 125 mV per channel over threshold
// - test mode gives a 1 V sawtooth at 30.518 Hz
// - occupancy mode gives 0.976 mV per filled buffer
// - level mode gives N/4096 volts from the host value
// - positive logic: any sample at or above threshold marks the group
// - negative logic: any sample strictly below threshold marks the group
// - memory clear pulse empties the output buffer
// - time-tag reset pulse restarts the event timestamp timer
module trig_mon_top
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // trigger sources
  input wire logic i_ext_trig,
  input wire logic i_sw_trig_wr,
  input wire logic i_ext_en,
  input wire logic i_sw_en,
  input wire logic i_loc_en,
  // trigger output source select
  input wire logic i_out_ext_en,
  input wire logic i_out_sw_en,
  input wire logic i_out_loc_en,
  // channel samples and discriminator settings
  input wire trig_mon_pkg::grp_t [`NCH-1:0] i_grp_data,
  input wire logic i_grp_valid,
  input wire logic i_grp_five,
  input wire trig_mon_pkg::smp_t [`NCH-1:0] i_thr,
  input wire logic [`NCH-1:0] i_neg_logic,
  input wire logic [`NCH-1:0][`NTH_W-1:0] i_nth,
  input wire logic [`NCH-1:0] i_ch_mask,
  input wire logic [`COINC_W-1:0] i_coinc_lvl,
  // board status for the default lvds map
  input wire logic i_mem_full,
  input wire logic i_evt_ready,
  input wire logic i_run,
  // lvds lines
  input wire logic [`NLVDS-1:0] i_lvds_in,
  input wire logic i_lvds_prog,
  input wire logic [`NLVDS-1:0] i_lvds_user_out,
  input wire logic [`NLVDS-1:0] i_lvds_user_oe_n,
  output logic [`NLVDS-1:0] o_lvds_out,
  output logic [`NLVDS-1:0] o_lvds_oe_n,
  // monitor settings
  input wire logic [`MODE_W-1:0] i_mon_mode,
  input wire logic [`DAC_W-1:0] i_mon_level,
  input wire logic [`DAC_W-1:0] i_buf_count,
  // results
  output logic o_glob_trig,
  output logic o_trig_out,
  output logic o_ttag_rst,
  output logic o_mem_clr,
  output logic [`DAC_W-1:0] o_dac_code,
  output logic o_dac_load
);
  // ---------------- channel discriminators ----------------
  chan_trig_if ct [`NCH] ();
  trig_mon_pkg::chmask_t over_all;
  trig_mon_pkg::chmask_t req_all;
  trig_mon_pkg::chmask_t loc_ok;

  genvar c;
  generate
    for (c = 0; c < `NCH; c++)
    begin : g_ch
      trig_mon_pkg::chmask_t others;
      assign ct[c].grp = i_grp_data[c];
      assign ct[c].grp_valid = i_grp_valid;
      assign ct[c].grp_five = i_grp_five;
      assign ct[c].thr = i_thr[c];
      assign ct[c].neg = i_neg_logic[c];
      assign ct[c].nth = i_nth[c];
      assign over_all[c] = ct[c].over;
      assign req_all[c] = ct[c].req;
      assign others = ct[c].over ? (over_all & ~(trig_mon_pkg::chmask_t'(1) << c)) : over_all;
      // enabled channel only, and enough other channels over in the same cycle
      assign loc_ok[c] = req_all[c] && i_ch_mask[c]
        && (trig_mon_pkg::popcount(others) >= {1'b0, i_coinc_lvl});
      chan_discrim u_disc
      (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .ct(ct[c])
      );
    end
  endgenerate

  // ---------------- synchronisers ----------------
  logic [`SYNC_W-1:0] ext_sync_r;
  logic [`NLVDS-1:0] lvds_s1_r;
  logic [`NLVDS-1:0] lvds_s2_r;
  logic [`NLVDS-1:0] lvds_s3_r;
  logic ext_s;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      ext_sync_r <= '0;
      lvds_s1_r <= '1;
      lvds_s2_r <= '1;
      lvds_s3_r <= '1;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[0], i_ext_trig};
      lvds_s1_r <= i_lvds_in;
      lvds_s2_r <= lvds_s1_r;
      lvds_s3_r <= lvds_s2_r;
    end
  end

  assign ext_s = ext_sync_r[`SYNC_W-1];

  // ---------------- trigger merge ----------------
  logic loc_any;
  logic trig_src;
  logic out_src;
  logic src_prev_r;
  logic glob_r;
  logic trig_out_r;

  assign loc_any = |loc_ok;
  // a level on the external input must not fire more than once
  assign trig_src = (ext_s && i_ext_en) || (i_sw_trig_wr && i_sw_en) || (loc_any && i_loc_en);
  assign out_src = (ext_s && i_out_ext_en) || (i_sw_trig_wr && i_out_sw_en) || (loc_any && i_out_loc_en);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      src_prev_r <= 1'b0;
      glob_r <= 1'b0;
      trig_out_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= trig_src;
      glob_r <= trig_src && !src_prev_r;
      trig_out_r <= out_src;
    end
  end

  assign o_glob_trig = glob_r;
  assign o_trig_out = trig_out_r;

  // ---------------- lvds front panel ----------------
  logic [`NLVDS-1:0] dflt_out;
  logic [`NLVDS-1:0] dflt_oe_n;
  logic [`NLVDS-1:0] lv_out_r;
  logic [`NLVDS-1:0] lv_oe_n_r;
  logic ttag_fall;
  logic clr_fall;
  logic ttag_r;
  logic clr_r;

  assign dflt_out = {4'h0, i_run, loc_any, i_evt_ready, i_mem_full, req_all};
  assign dflt_oe_n = ~`LV_OUT_MASK;
  assign ttag_fall = !i_lvds_prog && lvds_s3_r[`LV_TTAG_RST] && !lvds_s2_r[`LV_TTAG_RST];
  assign clr_fall = !i_lvds_prog && lvds_s3_r[`LV_MEM_CLR] && !lvds_s2_r[`LV_MEM_CLR];

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      lv_out_r <= '0;
      lv_oe_n_r <= '1;
      ttag_r <= 1'b0;
      clr_r <= 1'b0;
    end
    else
    begin
      lv_out_r <= i_lvds_prog ? i_lvds_user_out : dflt_out;
      lv_oe_n_r <= i_lvds_prog ? i_lvds_user_oe_n : dflt_oe_n;
      ttag_r <= ttag_fall;
      clr_r <= clr_fall;
    end
  end

  assign o_lvds_out = lv_out_r;
  assign o_lvds_oe_n = lv_oe_n_r;
  assign o_ttag_rst = ttag_r;
  assign o_mem_clr = clr_r;

  // ---------------- analog monitor ----------------
  logic [`DIV_W-1:0] div_r;
  logic dac_stb;
  logic [`SAW_W-1:0] saw_pre_r;
  logic [`DAC_W-1:0] saw_r;
  logic saw_step;
  logic [`DAC_W+3:0] maj_full;
  logic [`DAC_W+2:0] buf_full;
  logic [`DAC_W-1:0] maj_code;
  logic [`DAC_W-1:0] buf_code;
  logic [`DAC_W-1:0] mon_sel;
  logic [`DAC_W-1:0] dac_r;
  logic load_r;

  // codes past full scale stick at the top instead of wrapping
  function automatic logic [`DAC_W-1:0] clip_code(input logic [`DAC_W+3:0] v);
    return (v > (`DAC_W+4)'(`DAC_MAX)) ? `DAC_MAX : v[`DAC_W-1:0];
  endfunction

  assign dac_stb = (div_r == `DIV_W'(`DAC_DIV - 1));
  assign saw_step = dac_stb && (saw_pre_r == `SAW_W'(`SAW_DIV - 1));
  assign maj_full = (`DAC_W+4)'(trig_mon_pkg::popcount(over_all)) * (`DAC_W+4)'(`MAJ_STEP);
  // eight channels would need one code past full scale, so clip
  assign maj_code = clip_code(maj_full);
  assign buf_full = (`DAC_W+3)'(i_buf_count) * (`DAC_W+3)'(`BUF_STEP);
  assign buf_code = clip_code({1'b0, buf_full});
  assign mon_sel = (i_mon_mode == `MODE_MAJ) ? maj_code :
                   (i_mon_mode == `MODE_TEST) ? saw_r :
                   (i_mon_mode == `MODE_BUF) ? buf_code :
                   (i_mon_mode == `MODE_LEVEL) ? i_mon_level : `DAC_ZERO;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      div_r <= '0;
      saw_pre_r <= '0;
      saw_r <= `DAC_ZERO;
      dac_r <= `DAC_ZERO;
      load_r <= 1'b0;
    end
    else
    begin
      div_r <= dac_stb ? '0 : div_r + 1'b1;
      if (dac_stb)
      begin
        saw_pre_r <= saw_step ? '0 : saw_pre_r + 1'b1;
      end
      if (saw_step)
      begin
        saw_r <= saw_r + 1'b1;
      end
      if (dac_stb)
      begin
        dac_r <= mon_sel;
      end
      load_r <= dac_stb;
    end
  end

  assign o_dac_code = dac_r;
  assign o_dac_load = load_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_ext_held;
    i_ext_trig [*3];
  endsequence
  sequence s_clr_pulse;
    !i_lvds_prog && i_lvds_in[`LV_MEM_CLR] ##1 !i_lvds_prog && !i_lvds_in[`LV_MEM_CLR] [*2];
  endsequence
  sequence s_ttag_pulse;
    !i_lvds_prog && i_lvds_in[`LV_TTAG_RST] ##1 !i_lvds_prog && !i_lvds_in[`LV_TTAG_RST] [*2];
  endsequence

  a_glob_single_pulse: assert property (o_glob_trig |=> !o_glob_trig)
    else $error("global trigger held longer than one clock");
  a_ext_sync_lag: assert property (s_ext_held |-> ext_s)
    else $error("external trigger not through synchroniser in two clocks");
  a_ext_no_early: assert property ($rose(i_ext_trig) |-> !ext_sync_r[0])
    else $error("external trigger used before synchronisation");
  a_sw_trig_fires: assert property (i_sw_trig_wr && i_sw_en && !src_prev_r |=> o_glob_trig)
    else $error("software trigger write gave no global trigger");
  a_glob_cause: assert property (o_glob_trig |-> $past(trig_src) && !$past(src_prev_r))
    else $error("global trigger without an enabled source");
  a_coinc_lone: assert property (i_coinc_lvl != 3'h0 && $onehot(over_all) |-> !loc_any)
    else $error("lone channel triggered with coincidence required");
  a_mask_gate: assert property ((loc_ok & ~i_ch_mask) == '0)
    else $error("masked channel produced a local trigger");
  a_loc_not_direct: assert property (!i_loc_en && !i_ext_en && !i_sw_en |=> !o_glob_trig)
    else $error("trigger with every source disabled");
  a_trig_out_loc: assert property (loc_any && i_out_loc_en |=> o_trig_out)
    else $error("local trigger missing on trigger output");
  a_lvds_default: assert property (!i_lvds_prog |=> o_lvds_oe_n == ~`LV_OUT_MASK
    && o_lvds_out[`NCH-1:0] == $past(req_all))
    else $error("lvds default map wrong");
  a_mem_clr_pulse: assert property (s_clr_pulse |=> ##1 o_mem_clr)
    else $error("memory clear low pulse not seen");
  a_ttag_pulse: assert property (s_ttag_pulse |=> ##1 o_ttag_rst)
    else $error("time-tag reset low pulse not seen");
  a_dac_rate: assert property (o_dac_load |=> !o_dac_load ##1 o_dac_load)
    else $error("monitor update not every other clock");
  a_mon_level: assert property (dac_stb && i_mon_mode == `MODE_LEVEL |=> o_dac_code == $past(i_mon_level))
    else $error("level mode code differs from host value");
  a_maj_one: assert property (dac_stb && i_mon_mode == `MODE_MAJ && $onehot(over_all)
    |=> o_dac_code == 12'h0200)
    else $error("majority step not 125 mV");
  a_mode_rsvd: assert property (dac_stb && i_mon_mode == `MODE_RSVD |=> o_dac_code == `DAC_ZERO)
    else $error("reserved monitor mode drove a code");
  a_buf_step: assert property (dac_stb && i_mon_mode == `MODE_BUF && i_buf_count == 12'h0001
    |=> o_dac_code == 12'h0004)
    else $error("occupancy step wrong");
  a_retrig_block: assert property (src_prev_r |=> !o_glob_trig)
    else $error("global trigger repeated while sources stayed high");
  a_ext_fires: assert property (ext_s && i_ext_en && !src_prev_r |=> o_glob_trig)
    else $error("synchronised external trigger gave no global trigger");
  a_trig_out_sw: assert property (i_sw_trig_wr && i_out_sw_en |=> o_trig_out)
    else $error("software trigger missing on trigger output");
  a_lvds_user: assert property (i_lvds_prog |=> o_lvds_out == $past(i_lvds_user_out)
    && o_lvds_oe_n == $past(i_lvds_user_oe_n))
    else $error("lvds user map not applied");
  a_clr_ignored: assert property (i_lvds_prog |=> !o_mem_clr)
    else $error("memory clear taken while lines are user programmed");
  a_ttag_ignored: assert property (i_lvds_prog |=> !o_ttag_rst)
    else $error("time-tag reset taken while lines are user programmed");
  a_dac_hold: assert property (!dac_stb |=> $stable(o_dac_code))
    else $error("monitor code changed between updates");
  a_dac_test: assert property (dac_stb && i_mon_mode == `MODE_TEST |=> o_dac_code == $past(saw_r))
    else $error("test mode code is not the sawtooth");
  a_buf_clip: assert property (dac_stb && i_mon_mode == `MODE_BUF && i_buf_count > 12'h03FF
    |=> o_dac_code == `DAC_MAX)
    else $error("occupancy code not clipped at full scale");
endmodule
`default_nettype wire

// ### trig_fanout_model.sv
// behavioural fan-out unit that loops the board trigger output back to its trigger input
`timescale 1ns/100ps
`default_nettype none
module trig_fanout_model
(
  // board trigger output and loop control
  input wire logic i_trig_out,
  input wire logic i_loop_en,
  // level used when the crate loop is open
  input wire logic i_direct,
  // feeds the external trigger input of every board
  output logic o_ext_trig
);
  logic dly;
  // cable delay keeps the loop asynchronous to the board clock
  assign #3.3 dly = i_trig_out;
  // the originating board is fed back as well
  assign o_ext_trig = i_loop_en ? dly : i_direct;
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for trigger merge, lvds lines and monitor control
`timescale 1ns/100ps
`default_nettype none
`include "trig_mon_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic clk, nrst, ext_drv, loop_en, ext_trig, sw_wr, ext_en, sw_en, loc_en, oext, osw, oloc;
  trig_mon_pkg::grp_t [`NCH-1:0] grp;
  trig_mon_pkg::smp_t [`NCH-1:0] thr;
  logic [`NCH-1:0][`NTH_W-1:0] nth;
  logic valid, five, mem_full, evt_rdy, run, prog, glob, trig_out, ttag, mclr, dac_load;
  logic [`NCH-1:0] neg, mask;
  logic [`COINC_W-1:0] coinc;
  logic [`NLVDS-1:0] lv_in, u_out, u_oe_n, lv_out, lv_oe_n;
  logic [`MODE_W-1:0] mode;
  logic [`DAC_W-1:0] level, bufs, code, prev;
  logic [10:0] req_seen;
  int fail_count, cmp_count, glob_n, clr_n, tt_n, tout_n, cyc;

  trig_fanout_model u_trig_fanout_model (.i_trig_out(trig_out), .i_loop_en(loop_en), .i_direct(ext_drv),
    .o_ext_trig(ext_trig));

  trig_mon_top u_trig_mon_top (.i_clk(clk), .i_nrst(nrst), .i_ext_trig(ext_trig), .i_sw_trig_wr(sw_wr),
    .i_ext_en(ext_en), .i_sw_en(sw_en), .i_loc_en(loc_en), .i_out_ext_en(oext), .i_out_sw_en(osw),
    .i_out_loc_en(oloc), .i_grp_data(grp), .i_grp_valid(valid), .i_grp_five(five), .i_thr(thr),
    .i_neg_logic(neg), .i_nth(nth), .i_ch_mask(mask), .i_coinc_lvl(coinc), .i_mem_full(mem_full),
    .i_evt_ready(evt_rdy), .i_run(run), .i_lvds_in(lv_in), .i_lvds_prog(prog), .i_lvds_user_out(u_out),
    .i_lvds_user_oe_n(u_oe_n), .o_lvds_out(lv_out), .o_lvds_oe_n(lv_oe_n), .i_mon_mode(mode),
    .i_mon_level(level), .i_buf_count(bufs), .o_glob_trig(glob), .o_trig_out(trig_out), .o_ttag_rst(ttag),
    .o_mem_clr(mclr), .o_dac_code(code), .o_dac_load(dac_load));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulse counters, sampled once the edge has settled
  always @(posedge clk)
  begin
    #1;
    glob_n += int'(glob === 1'b1);
    clr_n += int'(mclr === 1'b1);
    tt_n += int'(ttag === 1'b1);
    tout_n += int'(trig_out === 1'b1);
    req_seen |= lv_out[10:0];
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("totals: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic zero();
    glob_n = 0;
    clr_n = 0;
    tt_n = 0;
    tout_n = 0;
    req_seen = 11'h000;
  endtask

  task automatic done(input string name);
    $display("%s test done: %0d compares, %0d mismatches", name, cmp_count, fail_count);
  endtask

  task automatic set_ch(input int c, input trig_mon_pkg::smp_t v);
    for (int s = 0; s < `NSAMP; s++)
    begin
      grp[c][s] = v;
    end
  endtask

  task automatic groups(input int n);
    valid = 1'b1;
    step(n);
    valid = 1'b0;
    step(4);
  endtask

  task automatic pulse();
    sw_wr = 1'b1;
    step(1);
    sw_wr = 1'b0;
  endtask

  task automatic load_wait();
    int k;
    k = 0;
    while (dac_load !== 1'b1 && k < 4)
    begin
      step(1);
      k++;
    end
    `CHK(dac_load, 1'b1)
  endtask

  task automatic mon_chk(input logic [`MODE_W-1:0] m, input logic [`DAC_W-1:0] e);
    mode = m;
    step(3);
    load_wait();
    `CHK(code, e)
  endtask

  task automatic t_sw();
    sw_en = 1'b1;
    osw = 1'b1;
    pulse();
    `CHK(glob, 1'b1)
    `CHK(trig_out, 1'b1)
    step(1);
    `CHK(glob, 1'b0)
    zero();
    sw_wr = 1'b1;
    step(2);
    sw_wr = 1'b0;
    step(3);
    `CHK(glob_n, 1)
    zero();
    pulse();
    step(1);
    pulse();
    step(3);
    `CHK(glob_n, 2)
    sw_en = 1'b0;
    zero();
    pulse();
    step(3);
    `CHK(glob_n, 0)
    done("software");
  endtask

  task automatic t_ext();
    ext_en = 1'b1;
    oext = 1'b1;
    osw = 1'b0;
    zero();
    ext_drv = 1'b1;
    step(2);
    `CHK(glob, 1'b0)
    step(1);
    `CHK(glob, 1'b1)
    step(6);
    `CHK(glob_n, 1)
    `CHK(trig_out, 1'b1)
    ext_drv = 1'b0;
    oext = 1'b0;
    osw = 1'b1;
    step(4);
    zero();
    loop_en = 1'b1;
    // software source itself disabled, so any trigger came round the loop
    pulse();
    step(8);
    `CHK(glob_n, 1)
    loop_en = 1'b0;
    osw = 1'b0;
    ext_en = 1'b0;
    done("external");
  endtask

  task automatic t_local();
    mask = 8'h04;
    oloc = 1'b1;
    zero();
    set_ch(2, 12'h064);
    groups(2);
    `CHK(req_seen, 11'h404)
    `CHK(tout_n, 1)
    `CHK(glob_n, 0)
    set_ch(2, 12'h063);
    groups(1);
    loc_en = 1'b1;
    zero();
    set_ch(2, 12'h064);
    groups(1);
    `CHK(glob_n, 0)
    groups(1);
    `CHK(glob_n, 1)
    groups(1);
    `CHK(glob_n, 1)
    set_ch(2, 12'h000);
    grp[2][4] = 12'hFFF;
    five = 1'b0;
    zero();
    groups(2);
    `CHK(glob_n, 0)
    five = 1'b1;
    set_ch(2, 12'h000);
    mask = 8'h20;
    neg[5] = 1'b1;
    set_ch(5, 12'h064);
    zero();
    groups(2);
    `CHK(glob_n, 0)
    grp[5][0] = 12'h063;
    groups(2);
    `CHK(glob_n, 1)
    neg[5] = 1'b0;
    set_ch(5, 12'h000);
    groups(1);
    // one other channel required, well below the eight enabled
    mask = 8'hFF;
    coinc = 3'h1;
    set_ch(2, 12'h0C8);
    zero();
    groups(2);
    `CHK(glob_n, 0)
    set_ch(6, 12'h0C8);
    groups(2);
    `CHK(glob_n, 1)
    coinc = 3'h0;
    oloc = 1'b0;
    loc_en = 1'b0;
    grp = '0;
    groups(1);
    done("local");
  endtask

  task automatic t_lvds();
    mem_full = 1'b1;
    run = 1'b1;
    step(2);
    `CHK(lv_out[15:8], 8'h09)
    `CHK(lv_oe_n, 16'hF000)
    zero();
    lv_in[13] = 1'b0;
    step(6);
    lv_in[13] = 1'b1;
    `CHK(clr_n, 1)
    lv_in[12] = 1'b0;
    step(6);
    lv_in[12] = 1'b1;
    `CHK(tt_n, 1)
    prog = 1'b1;
    u_out = 16'hA5C3;
    u_oe_n = 16'h0F0F;
    step(2);
    `CHK(lv_out, 16'hA5C3)
    `CHK(lv_oe_n, 16'h0F0F)
    lv_in[13] = 1'b0;
    step(6);
    lv_in[13] = 1'b1;
    `CHK(clr_n, 1)
    prog = 1'b0;
    mem_full = 1'b0;
    run = 1'b0;
    evt_rdy = 1'b1;
    step(4);
    `CHK(lv_out[15:8], 8'h02)
    evt_rdy = 1'b0;
    done("lvds");
  endtask

  task automatic t_mon();
    level = 12'hABC;
    mon_chk(3'h4, 12'hABC);
    bufs = 12'h00A;
    mon_chk(3'h3, 12'h028);
    bufs = 12'h7D0;
    mon_chk(3'h3, 12'hFFF);
    bufs = 12'h001;
    mon_chk(3'h3, 12'h004);
    mon_chk(3'h2, 12'h000);
    mon_chk(3'h5, 12'h000);
    set_ch(1, 12'h0C8);
    set_ch(3, 12'h0C8);
    set_ch(4, 12'h0C8);
    groups(1);
    // three channels over, 512 codes each
    mon_chk(3'h0, 12'h600);
    mode = 3'h1;
    step(3);
    load_wait();
    prev = code;
    // exactly 800 converter updates later the ramp has stepped once
    step(1600);
    `CHK(code, prev + 12'h001)
    step(1);
    `CHK(dac_load, 1'b0)
    done("monitor");
  endtask

  initial
  begin
    {ext_drv, loop_en, sw_wr, ext_en, sw_en, loc_en, oext, osw, oloc} = '0;
    {valid, mem_full, evt_rdy, run, prog} = '0;
    five = 1'b1;
    grp = '0;
    thr = {`NCH{12'h064}};
    nth = {`NCH{8'h02}};
    neg = '0;
    mask = '0;
    coinc = '0;
    lv_in = 16'hFFFF;
    u_out = '0;
    u_oe_n = 16'hFFFF;
    mode = '0;
    level = '0;
    bufs = '0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    nrst = 1'b0;
    zero();
    step(11);
    `CHK(lv_oe_n, 16'hFFFF)
    `CHK(glob, 1'b0)
    step(1);
    nrst = 1'b1;
    step(4);
    t_sw();
    t_ext();
    t_local();
    t_lvds();
    t_mon();
    close_out();
  end
endmodule
`default_nettype wire
